// ==== hdl/tvp_port_cfg.sv ====
// Purpose: per-pin configuration of the parallel I/O ports
// Assumes: pads resolve pin level from pinOut/pinOe; analog paths are
//          switched outside by pinInEn and the alternate selection
// Notes:   register bus is a plain strobe port, read data one cycle late
//
// Functional notes
// R1: every pin is software set to input, bidirectional, output or alternate.
// R2: weak pull-up mode leaves the pin undriven; no pull-up exists.
// R3: threshold TTL/CMOS per bit, except the fixed Schmitt bits.
// R4: each bit selects push-pull or open-drain drive.
// R5: software sets unbonded pins push-pull output early and keeps it; here absent bits never store a one and stay undriven.
// R6: pin configuration resets asynchronously on the reset pin.
// R7: reset puts all pins in weak pull-up, P5.0 in push-pull alternate out.
// R8: an alternate output on a pin also feeds that pin's alternate input.
// R9: a digital alternate input stays connected to its pin.
// R10: analog pin in alternate open-drain mode disconnects its digital input.
// R11: P0.3 and P0.4 carry analog channels zero and four.
// R12: P2.3 carries interrupt four, analog channel three, synth output two.
// R13: P5.0 alternate output is the delayed internal reset.
// R14: per-bit control is software writable; pin levels are readable.
`timescale 1ns/1ps
module tvp_port_cfg (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // pads
  input wire logic [39:0] pinIn,
  output logic [39:0] pinOut,
  output logic [39:0] pinOe,
  output logic [39:0] pinInEn,
  output logic [39:0] pinCmos,
  // alternate functions
  input wire logic [39:0] afOut,
  input wire logic delayedInternalResetOut,
  input wire logic tuningSynthOutTwo,
  output logic [39:0] afIn,
  output logic extIrqFourIn,
  output logic analogChannelZeroIn,
  output logic analogChannelFourIn,
  output logic analogChannelThreeIn
);

  // ==========================================================
  // helpers
  function automatic logic [39:0] putByte(
    input logic [39:0] v,
    input logic [2:0] p,
    input logic [7:0] b,
    input logic [39:0] keep
  );
    logic [39:0] r;
    r = v;
    for (int i = 0; i < tvp_pkg::NPIN; i++) begin
      if (i / tvp_pkg::PW == int'(p)) begin
        r[i] = b[i % tvp_pkg::PW] & keep[i];
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] getByte(
    input logic [39:0] v,
    input logic [2:0] p
  );
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < tvp_pkg::NPIN; i++) begin
      if (i / tvp_pkg::PW == int'(p)) begin
        r[i % tvp_pkg::PW] = v[i];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // control storage
  logic [39:0] outReg;
  logic [39:0] dirReg;
  logic [39:0] altReg;
  logic [39:0] odrReg;
  logic [39:0] thrReg;
  logic [39:0] wpuReg;
  logic [39:0] pinOutReg;
  logic [39:0] pinOeReg;
  logic [39:0] pinInEnReg;
  logic [39:0] afInReg;
  logic [7:0] rdataReg;
  logic [39:0] syncIn;

  // ==========================================================
  // address decode
  wire [2:0] selPort = addr[5:3];
  wire [2:0] selReg = addr[2:0];
  wire portOk = (selPort <= tvp_pkg::PORT_LAST);
  wire wrOk = wr && portOk;
  wire wrOut = wrOk && (selReg == tvp_pkg::REG_OUT);
  wire wrDir = wrOk && (selReg == tvp_pkg::REG_DIR);
  wire wrAlt = wrOk && (selReg == tvp_pkg::REG_ALT);
  wire wrOdr = wrOk && (selReg == tvp_pkg::REG_ODR);
  wire wrThr = wrOk && (selReg == tvp_pkg::REG_THR);
  wire wrWpu = wrOk && (selReg == tvp_pkg::REG_WPU);

  // the Schmitt bits keep no threshold choice and read back zero
  wire [39:0] thrKeep = tvp_pkg::PRESENT_MASK & ~tvp_pkg::SCHMITT_MASK;

  // absent bits never store a one, so they stay undriven
  wire [39:0] outNext = wrOut ?
    putByte(outReg, selPort, wdata, tvp_pkg::PRESENT_MASK) : outReg;
  wire [39:0] dirNext = wrDir ?
    putByte(dirReg, selPort, wdata, tvp_pkg::PRESENT_MASK) : dirReg;
  wire [39:0] altNext = wrAlt ?
    putByte(altReg, selPort, wdata, tvp_pkg::PRESENT_MASK) : altReg;
  wire [39:0] odrNext = wrOdr ?
    putByte(odrReg, selPort, wdata, tvp_pkg::PRESENT_MASK) : odrReg;
  wire [39:0] thrNext = wrThr ?
    putByte(thrReg, selPort, wdata, thrKeep) : thrReg;
  wire [39:0] wpuNext = wrWpu ?
    putByte(wpuReg, selPort, wdata, tvp_pkg::PRESENT_MASK) : wpuReg;

  // see R14
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      outReg <= tvp_pkg::OUT_RST;
      dirReg <= tvp_pkg::DIR_RST;
      altReg <= tvp_pkg::ALT_RST;
      odrReg <= tvp_pkg::ODR_RST;
      thrReg <= tvp_pkg::THR_RST;
      wpuReg <= tvp_pkg::WPU_RST;
    end else begin
      outReg <= outNext;
      dirReg <= dirNext;
      altReg <= altNext;
      odrReg <= odrNext;
      thrReg <= thrNext; // see R3
      wpuReg <= wpuNext;
    end
  end

  // ==========================================================
  // pad input synchroniser
  tvp_pin_sync #(
    .W(tvp_pkg::NPIN)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d(pinIn),
    .q(syncIn)
  );

  // ==========================================================
  // per-bit mode decode
  // dir=0 wpu=0 input, dir=0 wpu=1 weak pull-up (undriven),
  // dir=1 wpu=0 output (push-pull or open-drain by odr),
  // dir=1 wpu=1 bidirectional, which only ever pulls low
  logic [39:0] afOutEff;

  // fixed alternate outputs replace the generic lanes; see R12 R13
  always_comb begin
    afOutEff = afOut;
    afOutEff[tvp_pkg::PIN_P23] = tuningSynthOutTwo;
    afOutEff[tvp_pkg::PIN_P50] = delayedInternalResetOut;
  end

  wire [39:0] ppMode = dirReg & ~odrReg & ~wpuReg; // see R4
  wire [39:0] odLowOnly = odrReg | wpuReg;
  wire [39:0] afDrive = dirReg & altReg;
  wire [39:0] driveData = (altReg & afOutEff) | (~altReg & outReg);
  wire [39:0] afodMode = afDrive & odrReg;
  wire [39:0] anaAfod = afodMode & tvp_pkg::ANALOG_MASK;

  // an undriven mode never enables the driver; see R1 R2
  wire [39:0] oeNext = tvp_pkg::PRESENT_MASK & dirReg &
    (ppMode | ~driveData);
  wire [39:0] pinOutNext = tvp_pkg::PRESENT_MASK & ppMode & driveData;

  // analog pins in alternate open-drain lose the digital path; see R10
  wire [39:0] inEnNext = tvp_pkg::PRESENT_MASK & ~anaAfod;
  wire [39:0] digIn = syncIn & pinInEnReg;

  // alternate input follows the pin, or our own alternate output when
  // that output owns the pin; see R8 R9
  wire [39:0] afInNext = tvp_pkg::PRESENT_MASK &
    ((afDrive & afOutEff) | (~afDrive & digIn));

  // see R6 R7
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinOutReg <= tvp_pkg::PIN_OUT_RST;
      pinOeReg <= tvp_pkg::PIN_OE_RST;
      pinInEnReg <= tvp_pkg::PIN_INEN_RST;
      afInReg <= tvp_pkg::SYNC_RST;
    end else begin
      pinOutReg <= pinOutNext;
      pinOeReg <= oeNext;
      pinInEnReg <= inEnNext;
      afInReg <= afInNext;
    end
  end

  // ==========================================================
  // read back, data valid only in the cycle after the strobe
  logic [7:0] rdNext;

  always_comb begin
    rdNext = 8'h00;
    if (portOk) begin
      case (selReg)
        tvp_pkg::REG_OUT: rdNext = getByte(outReg, selPort);
        tvp_pkg::REG_DIR: rdNext = getByte(dirReg, selPort);
        tvp_pkg::REG_ALT: rdNext = getByte(altReg, selPort);
        tvp_pkg::REG_ODR: rdNext = getByte(odrReg, selPort);
        tvp_pkg::REG_THR: rdNext = getByte(thrReg, selPort);
        tvp_pkg::REG_WPU: rdNext = getByte(wpuReg, selPort);
        tvp_pkg::REG_PIN: rdNext = getByte(digIn, selPort); // see R14
        default: rdNext = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdataReg <= tvp_pkg::RDATA_RST;
    end else begin
      rdataReg <= rd ? rdNext : 8'h00;
    end
  end

  // ==========================================================
  // outputs
  assign rdata = rdataReg;
  assign pinOut = pinOutReg;
  assign pinOe = pinOeReg;
  assign pinInEn = pinInEnReg;
  assign pinCmos = thrReg;
  assign afIn = afInReg;
  // interrupt tap follows the alternate input; analog taps report the pin's alternate selection bit
  assign extIrqFourIn = afInReg[tvp_pkg::PIN_P23]; // see R12
  assign analogChannelZeroIn = altReg[tvp_pkg::PIN_P03]; // see R11
  assign analogChannelFourIn = altReg[tvp_pkg::PIN_P04]; // see R11
  assign analogChannelThreeIn = altReg[tvp_pkg::PIN_P23]; // see R12

  // ==========================================================
  // checks
  chk_reset_state: assert property ( // see R7
    @(posedge clk) disable iff (!arst_n)
    $rose(arst_n) |-> (pinOeReg == tvp_pkg::PIN_OE_RST) &&
      (wpuReg == tvp_pkg::WPU_RST) && (afDrive == tvp_pkg::DIR_RST)
  ) else $error("pins not in reset configuration after reset");

  chk_undriven_input: assert property ( // see R2
    @(posedge clk) disable iff (!arst_n)
    ##1 ((pinOeReg & ~$past(dirReg)) == 40'h00_00_00_00_00)
  ) else $error("input or weak pull-up pin is driven");

  chk_schmitt_fixed: assert property ( // see R3
    @(posedge clk) disable iff (!arst_n)
    (wr && selReg == tvp_pkg::REG_THR) |=>
      ((thrReg & tvp_pkg::SCHMITT_MASK) == 40'h00_00_00_00_00)
  ) else $error("Schmitt pin took a threshold choice");

  chk_od_no_high: assert property ( // see R4
    @(posedge clk) disable iff (!arst_n)
    ##1 (((pinOeReg & $past(odLowOnly) & ~$past(driveData)) ==
      ($past(dirReg) & $past(odLowOnly) & ~$past(driveData) &
      tvp_pkg::PRESENT_MASK)) &&
      ((pinOutReg & $past(odLowOnly)) == 40'h00_00_00_00_00))
  ) else $error("open-drain pin not pulling low on zero");

  chk_analog_isolate: assert property ( // see R10
    @(posedge clk) disable iff (!arst_n)
    (anaAfod != 40'h00_00_00_00_00) |=>
      ((pinInEnReg & $past(anaAfod)) == 40'h00_00_00_00_00)
  ) else $error("analog pin kept digital input path");

  chk_af_loopback: assert property ( // see R8
    @(posedge clk) disable iff (!arst_n)
    afDrive[tvp_pkg::PIN_P23] |=>
      (extIrqFourIn == $past(tuningSynthOutTwo))
  ) else $error("alternate output not looped to alternate input");

  chk_af_in_pin: assert property ( // see R9
    @(posedge clk) disable iff (!arst_n)
    (!afDrive[tvp_pkg::PIN_P23] && pinInEnReg[tvp_pkg::PIN_P23]) |=>
      (afInReg[tvp_pkg::PIN_P23] == $past(syncIn[tvp_pkg::PIN_P23]))
  ) else $error("digital alternate input lost its pin");

  chk_reset_out: assert property ( // see R13
    @(posedge clk) disable iff (!arst_n)
    ppMode[tvp_pkg::PIN_P50] && altReg[tvp_pkg::PIN_P50] |=>
      pinOeReg[tvp_pkg::PIN_P50] &&
      (pinOutReg[tvp_pkg::PIN_P50] == $past(delayedInternalResetOut))
  ) else $error("delayed reset not driven on its pin");

  chk_dir_write: assert property ( // see R14
    @(posedge clk) disable iff (!arst_n)
    (wr && addr == 6'h09) |=> (dirReg[15:8] == $past(wdata))
  ) else $error("direction write not stored");

  chk_read_slot: assert property ( // see R14
    @(posedge clk) disable iff (!arst_n)
    !rd |=> (rdata == 8'h00)
  ) else $error("read data outside its slot");

endmodule

// ==== shared/tvp_pkg.sv ====
// Purpose: constants shared by the port pin configuration logic
// Assumes: five 8-bit ports, packed as P0, P2, P3, P4, P5 (index 0..4)
// Notes:   pin vectors are 40 bits, bit = port_index*8 + bit_in_port
package tvp_pkg;

  // ==========================================================
  // geometry
  localparam int NPORT = 5;
  localparam int PW = 8;
  localparam int NPIN = 40;
  localparam int ADDR_W = 6;

  // ==========================================================
  // register index inside a port (address = port*8 + index)
  localparam logic [2:0] REG_OUT = 3'h0;
  localparam logic [2:0] REG_DIR = 3'h1;
  localparam logic [2:0] REG_ALT = 3'h2;
  localparam logic [2:0] REG_ODR = 3'h3;
  localparam logic [2:0] REG_THR = 3'h4;
  localparam logic [2:0] REG_WPU = 3'h5;
  localparam logic [2:0] REG_PIN = 3'h6;
  localparam logic [2:0] PORT_LAST = 3'h4;

  // ==========================================================
  // pin population and pad features
  localparam logic [39:0] PRESENT_MASK = 40'h67_C3_F7_FF_18;
  localparam logic [39:0] SCHMITT_MASK = 40'h00_03_73_31_00;
  localparam logic [39:0] ANALOG_MASK = 40'h00_00_00_0E_18;

  // single pins with fixed alternate routing
  localparam int PIN_P03 = 3;
  localparam int PIN_P04 = 4;
  localparam int PIN_P23 = 11;
  localparam int PIN_P50 = 32;

  // ==========================================================
  // values after reset
  localparam logic [39:0] OUT_RST = 40'h00_00_00_00_00;
  localparam logic [39:0] DIR_RST = 40'h01_00_00_00_00;
  localparam logic [39:0] ALT_RST = 40'h01_00_00_00_00;
  localparam logic [39:0] ODR_RST = 40'h00_00_00_00_00;
  localparam logic [39:0] THR_RST = 40'h00_00_00_00_00;
  localparam logic [39:0] WPU_RST = 40'h66_C3_F7_FF_18;
  localparam logic [39:0] PIN_OE_RST = 40'h01_00_00_00_00;
  localparam logic [39:0] PIN_OUT_RST = 40'h00_00_00_00_00;
  localparam logic [39:0] PIN_INEN_RST = 40'h67_C3_F7_FF_18;
  localparam logic [39:0] SYNC_RST = 40'h00_00_00_00_00;
  localparam logic [7:0] RDATA_RST = 8'h00;

endpackage

// ==== hdl/tvp_pin_sync.sv ====
// Purpose: two-flop synchroniser for the pad input levels
// Assumes: inputs are asynchronous to clk
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ps
module tvp_pin_sync #(
  parameter int W = 40
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // ==========================================================
  // two stages
  logic [W-1:0] metaReg;
  logic [W-1:0] stableReg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      metaReg <= '0;
      stableReg <= '0;
    end else begin
      metaReg <= d;
      stableReg <= metaReg;
    end
  end

  assign q = stableReg;

endmodule

// ==== verif/tvp_board.sv ====
// Purpose: board side of the port pads
// Assumes: no pull-up on the board or in the pads
// Notes:   a pad nobody drives reads a level that flips every cycle
`timescale 1ns/1ps
module tvp_board (
  // clock
  clk,
  // pads
  pinOut,
  pinOe,
  pinIn,
  // board drivers
  boardVal,
  boardEn
);
  input wire logic clk;
  input wire logic [39:0] pinOut;
  input wire logic [39:0] pinOe;
  output logic [39:0] pinIn;
  input wire logic [39:0] boardVal;
  input wire logic [39:0] boardEn;
  // =========================================
  // pad resolution
  logic [39:0] flt_reg = 40'h55_55_55_55_55;
  // floating pads flip so a settled unknown never looks valid
  always @(posedge clk) flt_reg <= ~flt_reg;
  assign pinIn = (pinOe & pinOut) | (~pinOe & boardEn & boardVal) |
    (~pinOe & ~boardEn & flt_reg);
endmodule

// ==== verif/tb_tvp_port_cfg.sv ====
// Purpose: self-checking bench for the port pin configuration
// Assumes: register map port*8+index, board drives every pad
// Notes:   reads are checked from a queue of expected bytes
`timescale 1ns/1ps
module tb_tvp_port_cfg;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [39:0] pinIn, pinOut, pinOe, pinInEn, pinCmos, afIn;
  logic [39:0] afOut = 40'h00_00_00_00_00;
  logic [39:0] afOutLast = 40'h00_00_00_00_00;
  logic [39:0] boardVal = 40'hA5_3C_96_5A_C3;
  // the board drives every pad, absent pins too; no unbonded-pin setup is done
  logic [39:0] boardEn = 40'hFF_FF_FF_FF_FF;
  logic delayedInternalResetOut = 1'b0;
  logic tuningSynthOutTwo = 1'b0;
  logic extIrqFourIn, analogChannelZeroIn;
  logic analogChannelFourIn, analogChannelThreeIn;
  logic rdSeen = 1'b0;
  logic [7:0] expQ[$];
  logic [31:0] seed = 32'h0000_3CD1;
  logic [39:0] thrExp = 40'h00_00_00_00_00;
  logic [39:0] rstTab [6] = '{tvp_pkg::OUT_RST, tvp_pkg::DIR_RST,
    tvp_pkg::ALT_RST, tvp_pkg::ODR_RST, tvp_pkg::THR_RST, tvp_pkg::WPU_RST};
  int fails = 0;
  int numChecks = 0;

  always #20 clk = ~clk;

  tvp_port_cfg u_tvp_port_cfg (.clk, .arst_n, .addr, .wdata, .wr, .rd,
    .rdata, .pinIn, .pinOut, .pinOe, .pinInEn, .pinCmos, .afOut,
    .delayedInternalResetOut, .tuningSynthOutTwo, .afIn, .extIrqFourIn,
    .analogChannelZeroIn, .analogChannelFourIn, .analogChannelThreeIn);
  tvp_board u_tvp_board (.clk, .pinOut, .pinOe, .pinIn, .boardVal,
    .boardEn);

  // =========================================
  // helpers
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic chk8(input string n, input logic [7:0] e,
    input logic [7:0] g);
    numChecks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk40(input string n, input logic [39:0] e,
    input logic [39:0] g);
    numChecks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wrReg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rdReg(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    expQ.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // =========================================
  // monitor and free-running stimulus
  always @(posedge clk) rdSeen <= rd;
  // generic lanes shift in a fresh random byte every cycle
  always @(posedge clk) afOut <= {afOut[31:0], rnd()};
  always @(posedge clk) afOutLast <= afOut;
  always @(negedge clk) begin
    if (rdSeen) begin
      chk8("rdata", expQ.pop_front(), rdata);
    end else begin
      chk8("rdata idle", 8'h00, rdata);
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    giveVerdict();
  end

  // =========================================
  // main sequence
  initial begin
    int p, r;
    logic [7:0] d, m;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    chk40("oe rst", tvp_pkg::PIN_OE_RST, pinOe);
    chk40("inen rst", tvp_pkg::PIN_INEN_RST, pinInEn);
    chk40("out rst", tvp_pkg::PIN_OUT_RST, pinOut);
    chk40("afin rst", tvp_pkg::SYNC_RST, afIn);
    for (p = 0; p < 5; p++) begin
      for (r = 0; r < 6; r++) begin
        rdReg(6'(p * 8 + r), rstTab[r][p * 8 +: 8]);
      end
    end
    rdReg(6'h07, 8'h00);
    rdReg(6'h28, 8'h00);
    @(posedge clk);
    delayedInternalResetOut <= 1'b1;
    tick(2);
    chk40("p50", 40'h01_00_00_00_00,
      pinOut & pinOe & 40'h01_00_00_00_00);
    for (p = 0; p < 5; p++) begin
      for (r = 0; r < 6; r++) begin
        d = rnd();
        m = tvp_pkg::PRESENT_MASK[p * 8 +: 8];
        if (r == 4) m = m & ~tvp_pkg::SCHMITT_MASK[p * 8 +: 8];
        if (r == 4) thrExp[p * 8 +: 8] = d & m;
        wrReg(6'(p * 8 + r), d);
        rdReg(6'(p * 8 + r), d & m);
      end
    end
    tick(1);
    chk40("pinCmos", thrExp, pinCmos);
    // port 0 push-pull then open-drain output
    d = rnd();
    wrReg(6'h05, 8'h00);
    wrReg(6'h02, 8'h00);
    wrReg(6'h01, 8'hFF);
    wrReg(6'h00, d);
    for (r = 0; r < 2; r++) begin
      wrReg(6'h03, r ? 8'hFF : 8'h00);
      tick(1);
      chk8("p0 out", r ? 8'h00 : d & 8'h18, pinOut[7:0]);
      chk8("p0 oe", r ? ~d & 8'h18 : 8'h18, pinOe[7:0]);
    end
    // analog pins in alternate open-drain lose the digital path
    for (r = 0; r < 2; r++) begin
      wrReg(6'h02, r ? 8'h10 : 8'h08);
      tick(1);
      chk8("p0 inen", r ? 8'h08 : 8'h10, pinInEn[7:0]);
      chk8("adc sel", r ? 8'h02 : 8'h01,
        {6'h00, analogChannelFourIn, analogChannelZeroIn});
    end
    // port 4 digital input follows the pad in input and open-drain
    wrReg(6'h1D, 8'h00);
    wrReg(6'h1A, 8'h00);
    wrReg(6'h18, 8'hFF);
    wrReg(6'h1B, 8'hFF);
    for (r = 0; r < 2; r++) begin
      wrReg(6'h19, r ? 8'hFF : 8'h00);
      @(posedge clk);
      boardVal[31:24] <= rnd();
      tick(4);
      chk8("p4 afIn", boardVal[31:24] & 8'hC3, afIn[31:24]);
      rdReg(6'h1E, boardVal[31:24] & 8'hC3);
    end
    // port 2 bit 3 alternate push-pull with loopback
    wrReg(6'h0D, 8'h00);
    wrReg(6'h0B, 8'h00);
    wrReg(6'h0A, 8'h08);
    wrReg(6'h09, 8'h08);
    for (r = 1; r >= 0; r--) begin
      @(posedge clk);
      tuningSynthOutTwo <= r[0];
      tick(2);
      chk8("p23", {4'h0, r[0], r[0], r[0], 1'b1}, {4'h0, pinOut[11],
        afIn[11], extIrqFourIn, analogChannelThreeIn});
    end
    // whole port 2 on alternate outputs, bit 3 on the synth output, looped back to inputs
    wrReg(6'h0A, 8'hFF);
    wrReg(6'h09, 8'hFF);
    tick(2);
    d = {afOutLast[15:12], tuningSynthOutTwo, afOutLast[10:8]};
    chk8("p2 af out", d, pinOut[15:8]);
    chk8("p2 af loop", d, afIn[15:8]);
    // reset in mid-run acts without a clock edge
    #5 arst_n = 1'b0;
    #1 chk40("oe async", tvp_pkg::PIN_OE_RST, pinOe);
    chk40("out async", 40'h00_00_00_00_00, pinOut);
    chk40("inen async", tvp_pkg::PIN_INEN_RST, pinInEn);
    @(posedge clk);
    arst_n <= 1'b1;
    rdReg(6'h01, 8'h00);
    tick(2);
    giveVerdict();
  end
endmodule
